// ---- vip_arb.sv ----
// picks the highest effective priority among the candidates
// assumes the candidate index order is the arbitration ranking
`timescale 1ns/1ps
module vip_arb
    import vip_pkg::*;
(
    // candidates
    input wire logic [NUM_CAND-1:0] valid,
    input wire logic [NUM_CAND-1:0][EFF_W-1:0] prio,
    // winner
    output logic win_valid,
    output logic [3:0] win_idx,
    output logic [EFF_W-1:0] win_prio
);

    // =========================================================
    // scan
    always_comb begin
        win_valid = 1'b0;
        win_idx = 4'h0;
        win_prio = '0;
        for (int i = 0; i < NUM_CAND; i++) begin
            // strict compare keeps the lower index, the higher rank, on a tie
            if (valid[i] && (!win_valid || prio[i] > win_prio)) begin // see (R05)
                win_valid = 1'b1;
                win_idx = 4'(i);
                win_prio = prio[i];
            end
        end
    end

endmodule

// ---- vip_core_model.sv ----
// core stand-in: takes an offered vector with a one-cycle acknowledge
// assumes irq_req is registered on the same clock
`timescale 1ns/1ps
module vip_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // core side
    input wire logic irq_req,
    input wire logic ack_en,
    output logic core_ack
);
    // ==========================================
    // never two pulses in a row, a real core spends cycles on entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_ack <= 1'b0;
        end else begin
            core_ack <= ack_en && irq_req && !core_ack;
        end
    end
endmodule

// ---- vip_pkg.sv ----
// constants shared by the vectored interrupt priority unit and its helpers
// assumes a 32-bit axi4-lite register port with byte addresses in the low 8 bits
package vip_pkg;

    // =========================================================
    // sizes
    localparam int NUM_EVENTS = 9;
    localparam int NUM_SOFT = 7;
    localparam int NUM_CAND = NUM_EVENTS + NUM_SOFT;
    localparam int NUM_HW_TRAPS = 5;
    localparam int NUM_PAIRS = 6;
    localparam int ADDR_W = 8;
    localparam int PRIO_W = 3;
    localparam int EFF_W = 4;
    localparam int VEC_W = 16;

    // =========================================================
    // register byte offsets
    localparam logic [7:0] OFF_ENABLE_LOW = 8'h00;
    localparam logic [7:0] OFF_ENABLE_HIGH = 8'h04;
    localparam logic [7:0] OFF_PRIO_BASE = 8'h08;
    localparam logic [7:0] OFF_PRIO_LAST = 8'h1c;
    localparam logic [7:0] OFF_SOFT_REQ = 8'h20;
    localparam logic [7:0] OFF_SOFT_EN = 8'h24;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFF_VECTOR = 8'h30;

    // =========================================================
    // field layout and reset values
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PRIO_LO_LSB = 0;
    localparam int PRIO_HI_LSB = 4;
    localparam int NUM_LOW_EVENTS = 5;
    localparam int VEC_PENDING_BIT = 16;
    localparam int ST_EVENT_BIT = 0;
    localparam int ST_EXC_BIT = 1;
    localparam logic [7:0] ENABLE_LOW_MASK = 8'h9f;
    localparam logic [7:0] ENABLE_HIGH_MASK = 8'h0f;
    localparam logic [7:0] PRIO_MASK = 8'h77;
    localparam logic [7:0] SOFT_MASK = 8'hfe;
    localparam logic [1:0] STATUS_MASK = 2'h3;
    localparam logic [5:0] PAIR_USED = 6'h37;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] STATUS_RST = 2'h0;

    // =========================================================
    // priorities and vectors
    localparam logic [3:0] EFF_PRIO_OFFSET = 4'h8;
    localparam logic [15:0] RESET_VEC = 16'h0000;
    localparam logic [15:0] HW_TRAP_VEC_BASE = 16'h0004;
    localparam logic [15:0] TRAP_INSTR_VEC_BASE = 16'h0040;
    localparam logic [15:0] SOFT_VEC_BASE = 16'h0100;
    localparam int VEC_SHIFT = 2;
    // event order is the arbitration ranking, ranks 2 to 10
    localparam logic [15:0] EVENT_VEC [NUM_EVENTS] = '{16'h0080, 16'h0084, 16'h0088, 16'h008c,
                                                       16'h0090, 16'h00a0, 16'h00a4, 16'h00a8, 16'h00ac};
    localparam int EVENT_PAIR [NUM_EVENTS] = '{0, 0, 1, 1, 2, 4, 4, 5, 5};
    localparam bit EVENT_HI [NUM_EVENTS] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

    // =========================================================
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- vip_src_prio.sv ----
// one maskable event source: gating and effective priority
// assumes the request flag is a level from logic on the same clock
`timescale 1ns/1ps
module vip_src_prio
    import vip_pkg::*;
(
    // request and gating
    input wire logic flag,
    input wire logic enable,
    input wire logic global_en,
    input wire logic [PRIO_W-1:0] field,
    // result
    output logic valid,
    output logic [EFF_W-1:0] eff_prio
);

    // =========================================================
    // effective priority
    always_comb begin
        if (field == '0) begin
            eff_prio = '0; // see (R03)
        end else begin
            eff_prio = EFF_PRIO_OFFSET | {1'b0, field}; // see (R04)
        end
        valid = flag & enable & global_en & (field != '0); // see (R01) (R03)
    end

endmodule

// ---- vip_unit.sv ----
// vectored interrupt priority unit: registers, arbitration and vector to the core
// assumes peripheral flags are same-clock levels held until software clears them,
// and the core pulses core_ack for one cycle when it takes the offered vector
//
// Function
// (R01) nine event sources, own enables, global enable
// (R02) three-bit priority field per event source
// (R03) priority field zero disables the event
// (R04) nonzero field gives effective priority field plus eight
// (R05) equal priority ties resolved by fixed ranking
// (R06) reset vector 0000, highest rank
// (R07) five hardware traps at 0004 to 0014
// (R08) sixteen trap instructions vector 0040 to 007F
// (R09) external, timer vectors 0080 to 0090, ranks 2-6
// (R10) serial port vectors 00A0 to 00AC, ranks 7-10
// (R11) seven software interrupts, fixed priority k
// (R12) priority fields paired per nibble in six registers
// (R13) software clears serial flags, hardware never does
// (R14) accept only above current core priority
// (R15) nothing pending means no request, no vector
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module vip_unit
    import vip_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // event request flags
    input wire logic ext0_request_flag,
    input wire logic timer0_overflow_flag,
    input wire logic ext1_request_flag,
    input wire logic timer1_overflow_flag,
    input wire logic [1:0] timer2_shared_flags,
    input wire logic uart0_rx_flag,
    input wire logic uart0_tx_flag,
    input wire logic uart1_rx_flag,
    input wire logic uart1_tx_flag,
    // exceptions and traps
    input wire logic reset_exception_req,
    input wire logic [NUM_HW_TRAPS-1:0] hw_trap_req,
    input wire logic trap_instr_req,
    input wire logic [3:0] trap_instr_num,
    // core side
    input wire logic [EFF_W-1:0] core_priority,
    input wire logic core_ack,
    output logic irq_req,
    output logic [VEC_W-1:0] irq_vector,
    output logic irq_is_exception,
    // summary interrupt
    output logic intr
);

    // =========================================================
    // state
    logic [7:0] enable_low_reg, next_enable_low_reg;
    logic [7:0] enable_high_reg, next_enable_high_reg;
    logic [7:0] priority_pair_reg [NUM_PAIRS];
    logic [7:0] next_priority_pair_reg [NUM_PAIRS];
    logic [7:0] soft_irq_request, next_soft_irq_request;
    logic [7:0] soft_irq_enable, next_soft_irq_enable;
    logic [1:0] irq_status, next_irq_status;
    logic [1:0] irq_mask, next_irq_mask;
    logic aw_held, next_aw_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [7:0] w_data, next_w_data;
    logic w_strb0, next_w_strb0;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic next_irq_req;
    logic [VEC_W-1:0] next_irq_vector;
    logic next_irq_is_exception;

    // =========================================================
    // candidates and arbitration
    logic [NUM_EVENTS-1:0] event_flag;
    logic [NUM_CAND-1:0] cand_valid;
    logic [NUM_CAND-1:0][EFF_W-1:0] cand_prio;
    logic win_valid;
    logic [3:0] win_idx;
    logic [EFF_W-1:0] win_prio;
    logic global_irq_enable;

    assign global_irq_enable = enable_low_reg[GLOBAL_EN_BIT];
    // the two timer 2 flags share one vector
    assign event_flag = {uart1_tx_flag, uart1_rx_flag, uart0_tx_flag, uart0_rx_flag,
                         |timer2_shared_flags, timer1_overflow_flag, ext1_request_flag,
                         timer0_overflow_flag, ext0_request_flag}; // see (R09) (R10)

    for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_event
        logic src_enable;
        logic [PRIO_W-1:0] src_field;
        if (i < NUM_LOW_EVENTS) begin : g_lo
            assign src_enable = enable_low_reg[i];
        end else begin : g_hi
            assign src_enable = enable_high_reg[i-NUM_LOW_EVENTS];
        end
        if (EVENT_HI[i]) begin : g_nib_hi
            assign src_field = priority_pair_reg[EVENT_PAIR[i]][PRIO_HI_LSB +: PRIO_W]; // see (R12) (R02)
        end else begin : g_nib_lo
            assign src_field = priority_pair_reg[EVENT_PAIR[i]][PRIO_LO_LSB +: PRIO_W]; // see (R12) (R02)
        end
        vip_src_prio u_src (
            .flag(event_flag[i]),
            .enable(src_enable),
            .global_en(global_irq_enable),
            .field(src_field),
            .valid(cand_valid[i]),
            .eff_prio(cand_prio[i])
        );
    end

    for (genvar k = 1; k <= NUM_SOFT; k++) begin : g_soft
        assign cand_valid[NUM_EVENTS+k-1] = soft_irq_request[k] & soft_irq_enable[k]; // see (R11)
        assign cand_prio[NUM_EVENTS+k-1] = EFF_W'(k); // see (R11)
    end

    vip_arb u_arb (
        .valid(cand_valid),
        .prio(cand_prio),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_prio(win_prio)
    );

    // =========================================================
    // vector selection
    always_comb begin
        next_irq_req = 1'b0;
        next_irq_vector = '0; // see (R15)
        next_irq_is_exception = 1'b0;
        if (reset_exception_req) begin
            next_irq_req = 1'b1;
            next_irq_vector = RESET_VEC; // see (R06)
            next_irq_is_exception = 1'b1;
        end else if (|hw_trap_req) begin
            next_irq_req = 1'b1;
            next_irq_is_exception = 1'b1;
            // same rank: the lowest numbered trap goes first
            for (int t = NUM_HW_TRAPS - 1; t >= 0; t--) begin
                if (hw_trap_req[t]) begin
                    next_irq_vector = HW_TRAP_VEC_BASE + 16'(t << VEC_SHIFT); // see (R07)
                end
            end
        end else if (trap_instr_req) begin
            next_irq_req = 1'b1;
            next_irq_is_exception = 1'b1;
            next_irq_vector = TRAP_INSTR_VEC_BASE + {10'h000, trap_instr_num, 2'b00}; // see (R08)
        end else if (win_valid && win_prio > core_priority) begin // see (R14)
            next_irq_req = 1'b1;
            if (win_idx < 4'(NUM_EVENTS)) begin
                next_irq_vector = EVENT_VEC[win_idx]; // see (R09) (R10)
            end else begin
                next_irq_vector = SOFT_VEC_BASE + {10'h000, win_idx - 4'(NUM_EVENTS), 2'b00}; // see (R11)
            end
        end
    end

    // =========================================================
    // register bus
    logic do_write;
    logic ar_take;
    logic [7:0] wr_val;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign ar_take = s_axi_arvalid && !rvalid;
    assign wr_val = w_data;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'b00) && (a <= OFF_VECTOR);
    endfunction

    function automatic logic [31:0] read_reg(input logic [ADDR_W-1:0] a);
        logic [31:0] d;
        int p;
        d = '0;
        p = (int'(a) - int'(OFF_PRIO_BASE)) >> VEC_SHIFT;
        if (a == OFF_ENABLE_LOW) begin
            d[7:0] = enable_low_reg;
        end else if (a == OFF_ENABLE_HIGH) begin
            d[7:0] = enable_high_reg;
        end else if (a >= OFF_PRIO_BASE && a <= OFF_PRIO_LAST) begin
            d[7:0] = priority_pair_reg[p];
        end else if (a == OFF_SOFT_REQ) begin
            d[7:0] = soft_irq_request;
        end else if (a == OFF_SOFT_EN) begin
            d[7:0] = soft_irq_enable;
        end else if (a == OFF_IRQ_STATUS) begin
            d[1:0] = irq_status;
        end else if (a == OFF_IRQ_MASK) begin
            d[1:0] = irq_mask;
        end else if (a == OFF_VECTOR) begin
            d[VEC_PENDING_BIT] = irq_req;
            d[VEC_W-1:0] = irq_vector;
        end
        return d;
    endfunction

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb0 = w_strb0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata[7:0];
            next_w_strb0 = s_axi_wstrb[0];
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rdata = is_mapped(s_axi_araddr) ? read_reg(s_axi_araddr) : 32'h0000_0000;
            next_rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // =========================================================
    // register file
    logic wr_en;
    logic [1:0] status_set;

    assign wr_en = do_write && w_strb0;
    assign status_set = {core_ack & irq_req & irq_is_exception, core_ack & irq_req & !irq_is_exception};

    always_comb begin
        next_enable_low_reg = enable_low_reg;
        next_enable_high_reg = enable_high_reg;
        next_priority_pair_reg = priority_pair_reg;
        next_soft_irq_request = soft_irq_request;
        next_soft_irq_enable = soft_irq_enable;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr_en) begin
            if (aw_addr == OFF_ENABLE_LOW) begin
                next_enable_low_reg = wr_val & ENABLE_LOW_MASK; // see (R01)
            end
            if (aw_addr == OFF_ENABLE_HIGH) begin
                next_enable_high_reg = wr_val & ENABLE_HIGH_MASK; // see (R01)
            end
            for (int p = 0; p < NUM_PAIRS; p++) begin
                if (PAIR_USED[p] && aw_addr == OFF_PRIO_BASE + 8'(p << VEC_SHIFT)) begin
                    next_priority_pair_reg[p] = wr_val & PRIO_MASK; // see (R02) (R12)
                end
            end
            // the request flags stay set until software writes them back to zero
            if (aw_addr == OFF_SOFT_REQ) begin
                next_soft_irq_request = wr_val & SOFT_MASK; // see (R11)
            end
            if (aw_addr == OFF_SOFT_EN) begin
                next_soft_irq_enable = wr_val & SOFT_MASK; // see (R11)
            end
            if (aw_addr == OFF_IRQ_MASK) begin
                next_irq_mask = wr_val[1:0] & STATUS_MASK;
            end
            if (aw_addr == OFF_IRQ_STATUS) begin
                next_irq_status = irq_status & ~wr_val[1:0];
            end
        end
        // a delivery in the clearing cycle is kept
        next_irq_status = next_irq_status | status_set;
    end

    // =========================================================
    // flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_low_reg <= REG_RST;
            enable_high_reg <= REG_RST;
            for (int p = 0; p < NUM_PAIRS; p++) begin
                priority_pair_reg[p] <= REG_RST;
            end
            soft_irq_request <= REG_RST;
            soft_irq_enable <= REG_RST;
            irq_status <= STATUS_RST;
            irq_mask <= STATUS_RST;
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= REG_RST;
            w_strb0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            irq_req <= 1'b0;
            irq_vector <= '0;
            irq_is_exception <= 1'b0;
        end else begin
            enable_low_reg <= next_enable_low_reg;
            enable_high_reg <= next_enable_high_reg;
            priority_pair_reg <= next_priority_pair_reg;
            soft_irq_request <= next_soft_irq_request;
            soft_irq_enable <= next_soft_irq_enable;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb0 <= next_w_strb0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            irq_req <= next_irq_req;
            irq_vector <= next_irq_vector;
            irq_is_exception <= next_irq_is_exception;
        end
    end

    // =========================================================
    // outputs
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign intr = |(irq_status & irq_mask);

endmodule

// ---- vip_unit_checker.sv ----
// assertions on the core-side vector offer and the register bus answers
// assumes it is bound to vip_unit and sees only its ports
`timescale 1ns/1ps
module vip_unit_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // exceptions and core side
    input wire logic reset_exception_req,
    input wire logic [4:0] hw_trap_req,
    input wire logic trap_instr_req,
    input wire logic [3:0] trap_instr_num,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic irq_is_exception
);
    // ==========================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_idle_no_vector: assert property (!irq_req |-> irq_vector == 16'h0000)
        else $error("idle vector");
    a_reset_wins: assert property (reset_exception_req |=> irq_req && irq_is_exception && irq_vector == 16'h0000)
        else $error("reset vector");
    a_break_vector: assert property (!reset_exception_req && hw_trap_req[0] |=> irq_vector == 16'h0004)
        else $error("break vector");
    a_trap_vector: assert property (!reset_exception_req && hw_trap_req == 5'h00 && trap_instr_req
        |=> irq_is_exception && irq_vector == 16'h0040 + {$past(trap_instr_num), 2'b00})
        else $error("trap vector");
    a_exc_range: assert property (irq_is_exception |-> irq_req && irq_vector < 16'h0080 && irq_vector[1:0] == 2'b00)
        else $error("exception range");
    a_event_range: assert property (irq_req && !irq_is_exception
        |-> irq_vector >= 16'h0080 && irq_vector <= 16'h0118 && irq_vector[1:0] == 2'b00)
        else $error("event range");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read dropped");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write dropped");
endmodule

bind vip_unit vip_unit_checker vip_unit_checker_i (.clk, .rst_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .reset_exception_req, .hw_trap_req,
    .trap_instr_req, .trap_instr_num, .irq_req, .irq_vector, .irq_is_exception);

// ---- vip_unit_tb.sv ----
// self-checking bench for the vectored interrupt priority unit
// assumes the unit, checker and core model are compiled first
`timescale 1ns/1ps
module vip_unit_tb;
    // ==========================================
    // signals
    logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_exception_req, trap_instr_req;
    logic core_ack, ack_en, irq_req, irq_is_exception, intr;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, trap_instr_num, core_priority;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [9:0] ev;
    logic [4:0] hw_trap_req;
    logic [15:0] irq_vector, evv [10] = '{16'h0080, 16'h0084, 16'h0088, 16'h008c, 16'h0090,
                              16'h00a0, 16'h00a4, 16'h00a8, 16'h00ac, 16'h0090};
    int miscompares, checked, cyc;

    vip_unit vip_unit_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext0_request_flag(ev[0]),
        .timer0_overflow_flag(ev[1]), .ext1_request_flag(ev[2]), .timer1_overflow_flag(ev[3]),
        .timer2_shared_flags({ev[9], ev[4]}), .uart0_rx_flag(ev[5]), .uart0_tx_flag(ev[6]),
        .uart1_rx_flag(ev[7]), .uart1_tx_flag(ev[8]), .reset_exception_req, .hw_trap_req, .trap_instr_req,
        .trap_instr_num, .core_priority, .core_ack, .irq_req, .irq_vector, .irq_is_exception, .intr);
    vip_core_model vip_core_model_i (.clk, .rst_n, .irq_req, .ack_en, .core_ack);

    // ==========================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
        logic ha, hw;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        do begin
            @(negedge clk);
            {ha, hw} = {s_axi_awready, s_axi_wready};
            @(posedge clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !ha) || (s_axi_wvalid && !hw));
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            {ha, rr} = {s_axi_bvalid, s_axi_bresp};
            @(posedge clk);
        end while (!ha);
        s_axi_bready <= 1'b0;
        chk(rr, er);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
        logic ta;
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do begin
            @(negedge clk);
            ta = s_axi_arready;
            @(posedge clk);
        end while (!ta);
        {s_axi_arvalid, s_axi_rready} <= 2'b01;
        do begin
            @(negedge clk);
            {ta, rd, rr} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk);
        end while (!ta);
        s_axi_rready <= 1'b0;
        chk(rr, er);
        chk(rd, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // clock, timeout and scenarios
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ack_en} = '0;
        {reset_exception_req, trap_instr_req, ev, hw_trap_req, trap_instr_num, core_priority} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h00, 32'h0);
        rdc(8'h30, 32'h0);
        rdc(8'h34, 32'h0, 2'b10);
        wr(8'h02, 32'h0, 2'b10);
        wr(8'h14, 32'hff);
        rdc(8'h14, 32'h0);
        wr(8'h00, 32'h9f);
        wr(8'h04, 32'h0f);
        for (int p = 8; p <= 28; p += 4) wr(8'(p), 32'h11);
        for (int i = 0; i < 10; i++) begin
            ev <= 10'h001 << i;
            tick(2);
            rdc(8'h30, {15'h0, 1'b1, evv[i]});
        end
        ev <= 10'h003;
        rdc(8'h30, 32'h00010080);
        wr(8'h08, 32'h21);
        rdc(8'h30, 32'h00010084);
        wr(8'h08, 32'h20);
        ev <= 10'h001;
        rdc(8'h30, 32'h0);
        ev <= 10'h002;
        core_priority <= 4'ha;
        rdc(8'h30, 32'h0);
        core_priority <= 4'h9;
        rdc(8'h30, 32'h00010084);
        core_priority <= 4'h0;
        wr(8'h00, 32'h1f);
        rdc(8'h30, 32'h0);
        wr(8'h24, 32'hfe);
        for (int k = 1; k < 8; k++) begin
            wr(8'h20, 32'h1 << k);
            rdc(8'h30, 32'h00010100 + 32'(4 * (k - 1)));
        end
        wr(8'h00, 32'h9f);
        rdc(8'h30, 32'h00010084);
        wr(8'h2c, 32'h3);
        ack_en <= 1'b1;
        tick(4);
        @(posedge clk);
        ack_en <= 1'b0;
        ev <= 10'h000;
        wr(8'h20, 32'h0);
        rdc(8'h28, 32'h1);
        chk(intr, 32'h1);
        wr(8'h2c, 32'h0);
        chk(intr, 32'h0);
        wr(8'h28, 32'h1);
        rdc(8'h28, 32'h0);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            hw_trap_req <= 5'h01 << i;
            tick(2);
            chk(irq_vector, 16'h0004 + 16'(4 * i));
        end
        @(posedge clk);
        hw_trap_req <= 5'h00;
        trap_instr_req <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            @(posedge clk);
            trap_instr_num <= 4'(n);
            tick(2);
            chk(irq_vector, 16'h0040 + 16'(4 * n));
        end
        @(posedge clk);
        reset_exception_req <= 1'b1;
        ack_en <= 1'b1;
        tick(2);
        chk({irq_req, irq_is_exception, irq_vector}, 32'h30000);
        rdc(8'h28, 32'h2);
        @(posedge clk);
        {reset_exception_req, trap_instr_req, ack_en} <= 3'b000;
        tick(2);
        chk({irq_req, irq_vector}, 32'h0);
        final_report();
    end
endmodule
